// [hdl/psc_pkg.sv]
// Constants, field layout and carrier type for the power-on strap config block.
// Assumes a single CPU-side clock and an Avalon-MM register bus.
//
// Notes on behaviour
// RL1: Strap field reset value equals pulled line level
// RL2: Board leaves zero-strap lines undriven during reset
// RL3: Register 18 bits; top two show chip-selects
// RL4: Bits without hardware still hold their values
// RL5: Bit 14 selects big-endian processor support
// RL6: Bit 13 enables per-byte processor parity checks
// RL7: Memory parity passes; return data gets parity
// RL8: Bits 11/10 fast ROM: 9 not 12
// RL9: Software keeps ROM speed while running from it
// RL10: Bits 9/8 read-only ROM width indicators
// RL11: Bits 7-6 choose reset vector region
// RL12: 00 ROM1, 01 ROM0, 10 SDRAM
// RL13: 11 SDRAM and processor held in reset
// RL14: Bit 5 retries every PCI configuration cycle
// RL15: Boot software clears hold-off within milliseconds
// RL16: Bit 4 makes device the bus arbiter
// RL17: Arbiter off swaps request0/grant0 pin directions
// RL18: Controller role: bit 3 drives PCI reset
// RL19: Controller role set by dedicated strap pin
// RL20: Bits 2-0 select processor kind
// RL21: Straps sampled while system reset asserted
// RL22: Undriven data lines sample as zero
// RL23: Fields writable after reset unless read-only
// RL24: Captures follow lines, frozen at reset release

package psc_pkg;

    localparam int unsigned CFG_W        = 18;
    localparam int unsigned IOD_W        = 16;
    localparam int unsigned PIN_W        = 19;

    // Register word index on the bus
    localparam logic [1:0]  REG_CFG      = 2'h0;

    // Field positions
    localparam int unsigned BIT_BIG_END  = 14;
    localparam int unsigned BIT_PARITY   = 13;
    localparam int unsigned BIT_FAST1    = 11;
    localparam int unsigned BIT_FAST0    = 10;
    localparam int unsigned BIT_WIDE1    = 9;
    localparam int unsigned BIT_WIDE0    = 8;
    localparam int unsigned BIT_BOOT_LO  = 6;
    localparam int unsigned BIT_RETRY    = 5;
    localparam int unsigned BIT_ARBITER  = 4;
    localparam int unsigned BIT_PCI_RST  = 3;
    localparam int unsigned BIT_KIND_LO  = 0;

    // Software-writable bits: all but the ROM width indicators
    localparam logic [17:0] CFG_WMASK    = 18'h3fcff;
    localparam logic [17:0] CFG_RST      = 18'h00000;

    // ROM access lengths in CPU clocks
    localparam logic [3:0]  ROM_SLOW_CYC = 4'hc;
    localparam logic [3:0]  ROM_FAST_CYC = 4'h9;

    // Boot region codes and one-hot targets
    localparam logic [1:0]  BOOT_ROM1    = 2'h0;
    localparam logic [1:0]  BOOT_ROM0    = 2'h1;
    localparam logic [1:0]  BOOT_SDRAM   = 2'h2;
    localparam logic [1:0]  BOOT_UPLOAD  = 2'h3;
    localparam logic [2:0]  TGT_ROM1     = 3'h1;
    localparam logic [2:0]  TGT_ROM0     = 3'h2;
    localparam logic [2:0]  TGT_SDRAM    = 3'h4;

    // Processor kind codes
    localparam logic [2:0]  KIND_MODEL_A = 3'h0;
    localparam logic [2:0]  KIND_MODEL_B = 3'h1;
    localparam logic [2:0]  KIND_SERIAL  = 3'h4;

    typedef struct packed {
        logic [1:0] rom_chip_selects;
        logic       spare15;
        logic       processor_big_endian;
        logic       processor_parity_check_en;
        logic       spare12;
        logic       rom_sel1_fast_timing;
        logic       rom_sel0_fast_timing;
        logic       rom_sel1_wide;
        logic       rom_sel0_wide;
        logic [1:0] boot_region_select;
        logic       config_hold_off;
        logic       bus_arbitration_owner;
        logic       pci_reset_release;
        logic [2:0] processor_kind_select;
    } psc_cfg_t;

    typedef enum logic [1:0] {
        ST_CAPTURE = 2'b01,
        ST_RUN     = 2'b10
    } psc_state_t;

endpackage

// [hdl/psc_top.sv]
// Power-on strap configuration register with Avalon-MM slave access.
// Assumes RST_I is the system reset and strap pins settle while it is held.

`timescale 1ns/1ps
`default_nettype none

module psc_top
    import psc_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    input  wire logic [15:0] IO_DATA_LINES_I,
    input  wire logic [1:0]  ROM_CHIP_SELECTS_I,
    input  wire logic        HOST_ROLE_STRAP_N_I,
    input  wire logic [1:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    input  wire logic [3:0]  AVS_BYTEENABLE_I,
    output logic [31:0]      AVS_READDATA_O,
    output logic             AVS_WAITREQUEST_O,
    input  wire logic [31:0] CPU_DATA_I,
    input  wire logic [3:0]  CPU_PARITY_I,
    input  wire logic        CPU_DATA_VALID_I,
    input  wire logic [31:0] RETURN_DATA_I,
    input  wire logic [3:0]  MEM_PARITY_I,
    output logic             PARITY_ERROR_O,
    output logic [3:0]       RETURN_PARITY_O,
    output logic [3:0]       MEM_PARITY_O,
    output logic             PROCESSOR_BIG_ENDIAN_O,
    output logic             PROCESSOR_PARITY_CHECK_EN_O,
    output logic [3:0]       ROM_SEL0_CYCLES_O,
    output logic [3:0]       ROM_SEL1_CYCLES_O,
    output logic             ROM_SEL0_WIDE_O,
    output logic             ROM_SEL1_WIDE_O,
    output logic [2:0]       BOOT_TARGET_O,
    output logic             PROCESSOR_HOLD_RESET_O,
    output logic             PCI_CONFIG_RETRY_O,
    output logic             BUS_ARBITRATION_OWNER_O,
    output logic             REQ0_OE_O,
    output logic             GNT0_OE_O,
    output logic             PCI_RESET_N_O,
    output logic             PCI_RESET_OE_O,
    output logic [2:0]       PROCESSOR_KIND_SELECT_O,
    output logic             SERIAL_MODE_BITS_O
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [3:0] byte_parity(input logic [31:0] d);
        logic [3:0] p;
        p = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            p[i] = ^d[8*i +: 8];
        end
        return p;
    endfunction

    // ************************************************************
    // Reset synchroniser, defines the capture window
    // ************************************************************
    logic rsync1_ff;
    logic rsync2_ff;

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            rsync1_ff <= 1'b1;
            rsync2_ff <= 1'b1;
        end
        else
        begin
            rsync1_ff <= 1'b0;
            rsync2_ff <= rsync1_ff;
        end
    end

    // ************************************************************
    // Strap pin sampling: three stages, accept when 2nd and 3rd agree
    // ************************************************************
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s1_ff;
    logic [PIN_W-1:0] pin_s2_ff;
    logic [PIN_W-1:0] pin_s3_ff;
    logic [PIN_W-1:0] pin_filt_ff;
    logic [PIN_W-1:0] nxt_pin_filt;

    // Undriven lines arrive low through the pad pull-down
    assign pin_raw = {HOST_ROLE_STRAP_N_I, ROM_CHIP_SELECTS_I, IO_DATA_LINES_I}; // RL22

    always_comb
    begin
        for (int i = 0; i < PIN_W; i++)
        begin
            nxt_pin_filt[i] = (pin_s2_ff[i] == pin_s3_ff[i]) ? pin_s3_ff[i] : pin_filt_ff[i];
        end
    end

    // Free-running so straps are seen while reset is held
    always_ff @(posedge CLK_I)
    begin
        pin_s1_ff   <= pin_raw;
        pin_s2_ff   <= pin_s1_ff;
        pin_s3_ff   <= pin_s2_ff;
        pin_filt_ff <= nxt_pin_filt;
    end

    // ************************************************************
    // Capture / run sequencing and the configuration register
    // ************************************************************
    psc_state_t  state_ff;
    psc_state_t  nxt_state;
    psc_cfg_t    cfg_ff;
    psc_cfg_t    nxt_cfg;
    logic        role_n_ff;
    logic        nxt_role_n;
    logic        ack_ff;
    logic        nxt_ack;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        bus_req;
    logic        wr_ev;
    logic [17:0] be_mask;
    logic [17:0] wr_mask;

    assign bus_req = AVS_READ_I | AVS_WRITE_I;
    assign wr_ev   = AVS_WRITE_I & ack_ff & (AVS_ADDRESS_I == REG_CFG) & (state_ff == ST_RUN);
    assign be_mask = {{2{AVS_BYTEENABLE_I[2]}}, {8{AVS_BYTEENABLE_I[1]}},
                      {8{AVS_BYTEENABLE_I[0]}}};
    assign wr_mask = be_mask & CFG_WMASK; // RL10 RL23

    always_comb
    begin
        nxt_state  = state_ff;
        nxt_cfg    = cfg_ff;
        nxt_role_n = role_n_ff;
        unique case (state_ff)
            ST_CAPTURE:
            begin
                // Follow the lines until the reset window closes
                nxt_cfg    = psc_cfg_t'(pin_filt_ff[CFG_W-1:0]); // RL1 RL3 RL21 RL24
                nxt_role_n = pin_filt_ff[PIN_W-1]; // RL19
                if (!rsync2_ff)
                begin
                    nxt_state = ST_RUN; // RL24
                end
            end
            ST_RUN:
            begin
                if (wr_ev)
                begin
                    // Spare bits keep what is written
                    nxt_cfg = psc_cfg_t'((cfg_ff & ~wr_mask) |
                                         (AVS_WRITEDATA_I[CFG_W-1:0] & wr_mask)); // RL4 RL23
                end
            end
            default:
            begin
                nxt_state = ST_CAPTURE;
            end
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            state_ff  <= ST_CAPTURE;
            cfg_ff    <= psc_cfg_t'(CFG_RST);
            role_n_ff <= 1'b1;
        end
        else
        begin
            state_ff  <= nxt_state;
            cfg_ff    <= nxt_cfg;
            role_n_ff <= nxt_role_n;
        end
    end

    // ************************************************************
    // Avalon-MM slave: one wait cycle, answer on the second edge
    // ************************************************************
    always_comb
    begin
        nxt_ack   = bus_req & ~ack_ff;
        nxt_rdata = rdata_ff;
        if (AVS_READ_I & ~ack_ff)
        begin
            nxt_rdata = (AVS_ADDRESS_I == REG_CFG) ? {14'h0000, cfg_ff} : 32'h00000000;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h00000000;
        end
        else
        begin
            ack_ff   <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    assign AVS_WAITREQUEST_O = bus_req & ~ack_ff;
    assign AVS_READDATA_O    = rdata_ff;

    // ************************************************************
    // Processor data parity
    // ************************************************************
    logic       perr_ff;
    logic       nxt_perr;
    logic [3:0] rpar_ff;
    logic [3:0] mpar_ff;

    always_comb
    begin
        nxt_perr = CPU_DATA_VALID_I & cfg_ff.processor_parity_check_en &
                   (byte_parity(CPU_DATA_I) != CPU_PARITY_I); // RL6
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            perr_ff <= 1'b0;
            rpar_ff <= 4'h0;
            mpar_ff <= 4'h0;
        end
        else
        begin
            perr_ff <= nxt_perr;
            rpar_ff <= byte_parity(RETURN_DATA_I); // RL7
            mpar_ff <= MEM_PARITY_I; // RL7
        end
    end

    assign PARITY_ERROR_O  = perr_ff;
    assign RETURN_PARITY_O = rpar_ff;
    assign MEM_PARITY_O    = mpar_ff;

    // ************************************************************
    // Field decode to the steered units
    // ************************************************************
    logic [2:0] boot_tgt;

    always_comb
    begin
        unique case (cfg_ff.boot_region_select)
            BOOT_ROM1:   boot_tgt = TGT_ROM1; // RL11 RL12
            BOOT_ROM0:   boot_tgt = TGT_ROM0; // RL12
            BOOT_SDRAM:  boot_tgt = TGT_SDRAM; // RL12
            BOOT_UPLOAD: boot_tgt = TGT_SDRAM; // RL13
        endcase
    end

    assign PROCESSOR_BIG_ENDIAN_O      = cfg_ff.processor_big_endian; // RL5
    assign PROCESSOR_PARITY_CHECK_EN_O = cfg_ff.processor_parity_check_en;
    assign ROM_SEL0_CYCLES_O = cfg_ff.rom_sel0_fast_timing ? ROM_FAST_CYC : ROM_SLOW_CYC; // RL8
    assign ROM_SEL1_CYCLES_O = cfg_ff.rom_sel1_fast_timing ? ROM_FAST_CYC : ROM_SLOW_CYC; // RL8
    assign ROM_SEL0_WIDE_O   = cfg_ff.rom_sel0_wide; // RL10
    assign ROM_SEL1_WIDE_O   = cfg_ff.rom_sel1_wide; // RL10
    assign BOOT_TARGET_O     = boot_tgt;
    // Processor also held during the capture window
    assign PROCESSOR_HOLD_RESET_O = (state_ff == ST_CAPTURE) |
                                    (cfg_ff.boot_region_select == BOOT_UPLOAD); // RL13
    assign PCI_CONFIG_RETRY_O      = cfg_ff.config_hold_off; // RL14
    assign BUS_ARBITRATION_OWNER_O = cfg_ff.bus_arbitration_owner; // RL16
    assign GNT0_OE_O = cfg_ff.bus_arbitration_owner; // RL16 RL17
    assign REQ0_OE_O = ~cfg_ff.bus_arbitration_owner; // RL17
    // Only a bus controller drives the PCI reset
    assign PCI_RESET_OE_O = ~role_n_ff; // RL18 RL19
    assign PCI_RESET_N_O  = cfg_ff.pci_reset_release; // RL18
    assign PROCESSOR_KIND_SELECT_O = cfg_ff.processor_kind_select; // RL20
    assign SERIAL_MODE_BITS_O = (cfg_ff.processor_kind_select == KIND_SERIAL); // RL20

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence seq_cfg_write;
        wr_ev;
    endsequence

    sequence seq_bus_answer;
        AVS_WAITREQUEST_O ##1 (!AVS_WAITREQUEST_O && bus_req);
    endsequence

    AST_WIDTH_RO: assert property (@(posedge CLK_I) disable iff (RST_I) // RL10
        seq_cfg_write |=> $stable(cfg_ff.rom_sel1_wide) && $stable(cfg_ff.rom_sel0_wide))
        else $error("ROM width bits changed by a write");

    // Release edge skipped: cfg still shows its reset value there
    AST_CAPTURE: assert property (@(posedge CLK_I) disable iff (RST_I) // RL21
        !RST_I && (state_ff == ST_CAPTURE)
        |=> (cfg_ff == psc_cfg_t'($past(pin_filt_ff[CFG_W-1:0]))))
        else $error("Strap value not captured during reset window");

    AST_FREEZE: assert property (@(posedge CLK_I) disable iff (RST_I) // RL24
        (state_ff == ST_RUN) && !wr_ev |=> $stable(cfg_ff))
        else $error("Configuration moved without a write after release");

    AST_RELEASE: assert property (@(posedge CLK_I) disable iff (RST_I) // RL13
        seq_cfg_write ##0 (AVS_WRITEDATA_I[7:6] == BOOT_SDRAM) && AVS_BYTEENABLE_I[0]
        |=> !PROCESSOR_HOLD_RESET_O && (BOOT_TARGET_O == TGT_SDRAM))
        else $error("Processor not released after boot field change");

    AST_ROM_FAST: assert property (@(posedge CLK_I) disable iff (RST_I) // RL8
        seq_cfg_write ##0 AVS_BYTEENABLE_I[1] && AVS_WRITEDATA_I[BIT_FAST1]
        |=> (ROM_SEL1_CYCLES_O == 4'h9))
        else $error("Fast ROM select not giving 9 clocks");

    AST_PARITY_OFF: assert property (@(posedge CLK_I) disable iff (RST_I) // RL6
        !cfg_ff.processor_parity_check_en |=> !PARITY_ERROR_O)
        else $error("Parity error flagged while checks disabled");

    AST_PARITY_GEN: assert property (@(posedge CLK_I) disable iff (RST_I) // RL7
        1'b1 |=> (RETURN_PARITY_O == byte_parity($past(RETURN_DATA_I))) &&
                 (MEM_PARITY_O == $past(MEM_PARITY_I)))
        else $error("Parity generation or pass-through wrong");

    AST_RETRY: assert property (@(posedge CLK_I) disable iff (RST_I) // RL14
        seq_cfg_write ##0 AVS_BYTEENABLE_I[0] && AVS_WRITEDATA_I[BIT_RETRY]
        |=> PCI_CONFIG_RETRY_O)
        else $error("Configuration retry not enabled by write");

    AST_ARBITER: assert property (@(posedge CLK_I) disable iff (RST_I) // RL17
        (GNT0_OE_O != REQ0_OE_O) && (GNT0_OE_O == BUS_ARBITRATION_OWNER_O))
        else $error("Request/grant directions inconsistent with arbiter role");

    AST_ARBITER_WR: assert property (@(posedge CLK_I) disable iff (RST_I) // RL16
        seq_cfg_write ##0 AVS_BYTEENABLE_I[0]
        |=> (BUS_ARBITRATION_OWNER_O == $past(AVS_WRITEDATA_I[BIT_ARBITER])) &&
            (GNT0_OE_O == BUS_ARBITRATION_OWNER_O))
        else $error("Arbiter role not taken from written bit");

    AST_BUS: assert property (@(posedge CLK_I) disable iff (RST_I)
        $rose(bus_req) |-> seq_bus_answer)
        else $error("Bus answer not given on second edge");

endmodule

`default_nettype wire

// [verification/psc_strap_board.sv]
// Board side of the strap lines: pull-up resistors where a field should read 1.
// Assumes the pad pull-down turns every unstrapped, undriven line into 0.
`timescale 1ns/1ps
`default_nettype none

module psc_strap_board
(
    input  wire logic [15:0] pull_up_i,
    output logic [15:0]      io_data_lines_o
);
    // Sharing devices tri-state in reset; pad pull-down wins elsewhere
    assign io_data_lines_o = pull_up_i;
endmodule

`default_nettype wire

// [verification/power_on_strap_config_test.sv]
// Self-checking bench for the strap configuration register, with a reference model.
// Assumes psc_top, psc_pkg and the board strap model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module power_on_strap_config_test import psc_pkg::*;;
    logic clk = 1'b0, rst = 1'b1, host_n = 1'b1, rd = 1'b0, wr = 1'b0, cpu_valid = 1'b0;
    logic [15:0] pull_up = 16'h0, iod;
    logic [1:0]  romcs = 2'h0, addr = 2'h0;
    logic [31:0] wdata = 32'h0, rdata, cpu_data = 32'h0, ret_data = 32'h0, rd_val;
    logic [3:0]  be = 4'h0, cpu_par = 4'h0, mem_par = 4'h0, ret_par, mem_par_o, cyc0, cyc1;
    logic [2:0]  btgt, kind;
    logic waitreq, par_err, big, paren, w0, w1, hold, retry, arb, req_oe, gnt_oe;
    logic prst_n, prst_oe, serial, host_cap;
    int num_errors = 0, total_checks = 0, seed = 3543, mdl = 0;

    always #12.5 clk = ~clk;

    psc_strap_board psc_strap_board_inst (.pull_up_i(pull_up), .io_data_lines_o(iod));

    psc_top psc_top_inst (
        .CLK_I(clk), .RST_I(rst), .IO_DATA_LINES_I(iod), .ROM_CHIP_SELECTS_I(romcs),
        .HOST_ROLE_STRAP_N_I(host_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .CPU_DATA_I(cpu_data),
        .CPU_PARITY_I(cpu_par), .CPU_DATA_VALID_I(cpu_valid), .RETURN_DATA_I(ret_data),
        .MEM_PARITY_I(mem_par), .PARITY_ERROR_O(par_err), .RETURN_PARITY_O(ret_par),
        .MEM_PARITY_O(mem_par_o), .PROCESSOR_BIG_ENDIAN_O(big),
        .PROCESSOR_PARITY_CHECK_EN_O(paren), .ROM_SEL0_CYCLES_O(cyc0),
        .ROM_SEL1_CYCLES_O(cyc1), .ROM_SEL0_WIDE_O(w0), .ROM_SEL1_WIDE_O(w1),
        .BOOT_TARGET_O(btgt), .PROCESSOR_HOLD_RESET_O(hold), .PCI_CONFIG_RETRY_O(retry),
        .BUS_ARBITRATION_OWNER_O(arb), .REQ0_OE_O(req_oe), .GNT0_OE_O(gnt_oe),
        .PCI_RESET_N_O(prst_n), .PCI_RESET_OE_O(prst_oe), .PROCESSOR_KIND_SELECT_O(kind),
        .SERIAL_MODE_BITS_O(serial)
    );

    // ************************************************************
    // Compare, verdict and bus tasks
    // ************************************************************
    task automatic chk_bus(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_pin(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic close_out();
        if (num_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Request held until waitrequest is sampled low
    task automatic bus(input logic is_wr, input logic [1:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        @(posedge clk);
        rd <= !is_wr;
        wr <= is_wr;
        addr <= a;
        wdata <= d;
        be <= b;
        do @(posedge clk); while (waitreq !== 1'b0);
        rd_val = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wr_cfg(input logic [1:0] a, input logic [31:0] d, input logic [3:0] b);
        int m;
        m = (b[0] ? 32'hff : 32'h0) | (b[1] ? 32'hff00 : 32'h0) | (b[2] ? 32'h30000 : 32'h0);
        m = m & 32'(CFG_WMASK);
        bus(1'b1, a, d, b);
        if (a == 2'h0)
            mdl = (mdl & ~m) | (d & m);
    endtask

    function automatic logic [3:0] par4(input logic [31:0] d);
        return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
    endfunction

    task automatic chk_outs();
        logic [1:0]  bt;
        logic [25:0] e;
        bt = mdl[7:6];
        e = {mdl[14], mdl[13], mdl[11] ? 4'h9 : 4'hc, mdl[10] ? 4'h9 : 4'hc, mdl[9], mdl[8],
             bt == 2'h0 ? 3'h1 : bt == 2'h1 ? 3'h2 : 3'h4, bt == 2'h3, mdl[5], mdl[4],
             mdl[4], !mdl[4], mdl[3], !host_cap, mdl[2:0], mdl[2:0] == 3'h4};
        chk_pin("outputs", {6'h0, e}, {6'h0, big, paren, cyc1, cyc0, w1, w0, btgt, hold,
                retry, arb, gnt_oe, req_oe, prst_n, prst_oe, kind, serial});
    endtask

    // Straps applied in reset, then disturbed once the capture is over
    task automatic do_reset(input logic [17:0] strap, input logic hn);
        @(posedge clk);
        rst <= 1'b1;
        pull_up <= strap[15:0];
        romcs <= strap[17:16];
        host_n <= hn;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        mdl = 32'(strap);
        host_cap = hn;
        repeat (4) @(posedge clk);
        pull_up <= ~strap[15:0];
        romcs <= ~strap[17:16];
        host_n <= ~hn;
        bus(1'b0, 2'h0, 32'h0, 4'hf);
        chk_bus("cfg_after_reset", 32'(mdl), rd_val);
        @(negedge clk);
        chk_outs();
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        logic [31:0] d, cd, rdt;
        logic [3:0]  b, mp;
        logic [2:0]  kinds [3] = '{3'h0, 3'h1, 3'h4};
        d = $random(seed);
        do_reset(d[17:0], 1'b0);
        do_reset(~d[17:0], 1'b1);
        for (int i = 0; i < 12; i++)
        begin
            d = $random(seed);
            d[7:6] = i[1:0];
            d[2:0] = kinds[i % 3];
            b = (i < 4) ? 4'hf : 4'($random(seed));
            wr_cfg(2'h0, d, b);
            wr_cfg(2'(1 + i % 3), $random(seed), 4'hf);
            bus(1'b0, 2'h0, 32'h0, 4'hf);
            chk_bus("cfg_readback", 32'(mdl), rd_val);
            bus(1'b0, 2'(1 + i % 3), 32'h0, 4'hf);
            chk_bus("unmapped_read", 32'h0, rd_val);
            @(negedge clk);
            chk_outs();
        end
        for (int i = 0; i < 16; i++)
        begin
            if (i % 8 == 0)
                wr_cfg(2'h0, (i == 0) ? 32'h0 : 32'h2000, 4'h3);
            cd = $random(seed);
            rdt = $random(seed);
            mp = 4'($random(seed));
            @(posedge clk);
            cpu_data <= cd;
            cpu_par <= par4(cd) ^ {3'h0, i[0]};
            cpu_valid <= 1'b1;
            ret_data <= rdt;
            mem_par <= mp;
            @(posedge clk);
            #1;
            chk_pin("parity_error", {31'h0, i[0] & mdl[13]}, {31'h0, par_err});
            chk_pin("return_parity", {28'h0, par4(rdt)}, {28'h0, ret_par});
            chk_pin("mem_parity", {28'h0, mp}, {28'h0, mem_par_o});
        end
        close_out();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        close_out();
    end
endmodule

`default_nettype wire
